//--- hdl/codec_pkg.sv
/*
 * Constants, register map and packet carrier for the switch-state packet codec.
 * Assumes a 200 MHz mclk; all millisecond figures are counted on a 1 ms tick.
 */
package codec_pkg;

    // --------------------
    // Clock and timing
    // --------------------
    localparam int CLK_PERIOD_NS = 5;
    localparam int MS_NS = 1_000_000;
    localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
    localparam int PULLDOWN_NS = 1_000;
    localparam int PULLDOWN_CYCLES = (PULLDOWN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READY_MS = 3;
    localparam int GAP_MS = 15;
    localparam int REPEAT_MS = 15;
    localparam int HANG_SHORT_MS = 20;
    localparam int HANG_LONG_MS = 500;
    localparam int BEACON_MS = 2_000;

    // --------------------
    // State byte layout
    // --------------------
    localparam int BIT_BEACON = 0;
    localparam int BIT_IN1 = 4;
    localparam int BIT_IN3 = 6;
    localparam int PKT_BYTES = 5;
    localparam logic [2:0] LEN_STATE_ONLY = 3'h1;
    localparam logic [2:0] LEN_FULL = 3'h5;

    // --------------------
    // Register map
    // --------------------
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_OWN_ID = 12'h008;
    localparam logic [11:0] OFS_PKT_CNT = 12'h00C;
    localparam int CTRL_LEARN = 0;
    localparam int CTRL_FORGET = 1;
    localparam logic [31:0] OWN_ID_RESET = 32'h0000_0001;

    // --------------------
    // Types
    // --------------------
    typedef enum logic [2:0]
    {
        MODE_TX = 3'b000,
        MODE_TX_BEACON = 3'b001,
        MODE_SER = 3'b010,
        MODE_SER_NET = 3'b011,
        MODE_RX_LONG = 3'b100,
        MODE_RX_LONG_NET = 3'b101,
        MODE_RX_SHORT = 3'b110,
        MODE_RX_SHORT_NET = 3'b111
    } mode_t;

    typedef enum logic [1:0]
    {
        ST_STRAP = 2'b00,
        ST_WAIT = 2'b01,
        ST_RUN = 2'b10
    } phase_t;

    typedef struct packed
    {
        logic [2:0] len;
        logic [31:0] hdr_id;
        logic [PKT_BYTES-1:0][7:0] data;
    } radio_pkt_t;

endpackage : codec_pkg

//--- hdl/ms_tick_gen.sv
/*
 * Millisecond tick divider with synchronous restart.
 * Assumes a single clock; tick is a one-cycle enable pulse.
 */
`timescale 1ns/100ps
module ms_tick_gen #(
    parameter int DIV = 200_000
)(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clr,
    output logic tick_r
);

    logic [31:0] cnt_r;
    logic [31:0] cnt_nxt;
    logic tick_nxt;

    always_comb
    begin
        tick_nxt = 1'b0;
        cnt_nxt = cnt_r + 32'h0000_0001;
        if (clr)
        begin
            cnt_nxt = 32'h0000_0000;
        end
        else if (cnt_r == 32'(DIV - 1))
        begin
            cnt_nxt = 32'h0000_0000;
            tick_nxt = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_r <= 32'h0000_0000;
            tick_r <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

endmodule : ms_tick_gen

//--- hdl/switch_state_packet_codec.sv
/*
 * Switch-state packet codec: mode strap, switch transmitter, serial framing,
 * identifier filter and learning, switch receiver with hang time, APB registers.
 * Assumes a radio layer that takes rf_tx pulses at once and delivers rf_rx pulses.
 */
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/100ps
// Notes on behaviour
// RULE_01: Packet is state byte then four id bytes
// RULE_02: Serial modes forward accepted packets unchanged
// RULE_03: Inputs 3..1 go in bits 6..4
// RULE_04: Beacon sets bits 0 and 4
// RULE_05: Bit 0 clear means switch-driven packet
// RULE_06: Serial output id equals header id; code forwards the received id bytes unchanged instead
// RULE_07: Unlearned sender in network serial discarded
// RULE_08: Receiver treats serial packets like switch packets
// RULE_09: Fifteen ms idle gap closes serial packet
// RULE_10: Single zero byte clears outputs immediately
// RULE_11: Non-network receiver accepts every packet
// RULE_12: Network receiver needs learned header id
// RULE_13: Five-byte packet needs own id match
// RULE_14: Learning stores header id only
// RULE_15: Three mode pins sampled once after reset
// RULE_16: Pull-down on pin 0 only while sampling
// RULE_17: Ready about three ms after reset
// RULE_18: Outputs follow received state bits
// RULE_19: Hang time restarts on each accepted packet
// RULE_20: Unused state bits sent zero, ignored
module switch_state_packet_codec import codec_pkg::*; #(
    parameter int MS_DIV = MS_CYCLES,
    parameter int LEARN_DEPTH = 4,
    parameter int BEACON_INTERVAL_MS = BEACON_MS
)(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic mode_pin_0,
    input wire logic mode_pin_1,
    input wire logic mode_pin_2,
    output logic mode_pin_0_pd_en,
    input wire logic [2:0] switch_in,
    input wire logic learn_pin,
    output logic learn_led,
    output logic switch_output_1,
    output logic switch_output_2,
    output logic switch_output_3,
    input wire logic ser_rx_valid,
    input wire logic [7:0] ser_rx_data,
    output logic ser_tx_valid,
    output logic [7:0] ser_tx_data,
    input wire logic ser_tx_ready,
    input wire logic rf_rx_valid,
    input wire radio_pkt_t rf_rx_pkt,
    output logic rf_tx_valid,
    output radio_pkt_t rf_tx_pkt
);

    // --------------------
    // State
    // --------------------
    phase_t phase_r, phase_nxt;
    mode_t mode_r, mode_nxt;
    logic [15:0] tcnt_r, tcnt_nxt;
    logic pd_r, pd_nxt;
    logic [2:0] outs_r, outs_nxt;
    logic [9:0] hang_r, hang_nxt;
    logic [2:0] last_in_r, last_in_nxt;
    logic [4:0] rep_r, rep_nxt;
    logic [15:0] bcn_r, bcn_nxt;
    logic rf_tx_valid_r, rf_tx_valid_nxt;
    radio_pkt_t rf_tx_pkt_r, rf_tx_pkt_nxt;
    radio_pkt_t sin_r, sin_nxt;
    logic [4:0] gap_r, gap_nxt;
    radio_pkt_t sout_r, sout_nxt;
    logic [2:0] sidx_r, sidx_nxt;
    logic ser_tx_valid_r, ser_tx_valid_nxt;
    logic [7:0] ser_tx_data_r, ser_tx_data_nxt;
    logic learning_r, learning_nxt;
    logic learn_pin_r;
    logic [31:0] ids_r [LEARN_DEPTH];
    logic [LEARN_DEPTH-1:0] idv_r, idv_nxt;
    logic [$clog2(LEARN_DEPTH)-1:0] wptr_r, wptr_nxt;
    logic [31:0] own_id_r, own_id_nxt;
    logic [31:0] pkt_cnt_r, pkt_cnt_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;

    logic tick;
    logic run, net, is_rx, is_ser, known, addr_ok, accept, zero_pkt, learn_req;
    logic apb_done, arm_learn, forget;
    logic [LEARN_DEPTH-1:0] hit;
    logic [9:0] hang_ms;

    ms_tick_gen #(.DIV(MS_DIV)) u_tick (
        .mclk(mclk),
        .rst_n(rst_n),
        .clr(1'b0),
        .tick_r(tick)
    );

    // --------------------
    // Identifier filter
    // --------------------
    genvar gi;
    generate
        for (gi = 0; gi < LEARN_DEPTH; gi++)
        begin : g_hit
            assign hit[gi] = idv_r[gi] && (ids_r[gi] == rf_rx_pkt.hdr_id);
        end
    endgenerate

    assign run = (phase_r == ST_RUN);
    assign is_rx = mode_r[2];
    assign is_ser = (mode_r[2:1] == 2'b01);
    assign net = mode_r[0] && (is_rx || is_ser);
    assign known = |hit;
    // RULE_13: own id check
    assign addr_ok = !(is_rx && net && rf_rx_pkt.len == LEN_FULL)
        || ({rf_rx_pkt.data[1], rf_rx_pkt.data[2], rf_rx_pkt.data[3], rf_rx_pkt.data[4]}
        == own_id_r);
    // RULE_07 RULE_11 RULE_12: header id acceptance
    assign accept = run && rf_rx_valid && (is_rx || is_ser) && (!net || known) && addr_ok;
    assign zero_pkt = (rf_rx_pkt.len == LEN_STATE_ONLY) && (rf_rx_pkt.data[0] == 8'h00);
    assign hang_ms = mode_r[1] ? 10'(HANG_SHORT_MS + 1) : 10'(HANG_LONG_MS + 1);
    assign apb_done = psel && penable && pready_r;
    assign arm_learn = apb_done && pwrite && paddr == OFS_CTRL && pwdata[CTRL_LEARN];
    assign forget = apb_done && pwrite && paddr == OFS_CTRL && pwdata[CTRL_FORGET];
    assign learn_req = net && ((learn_pin && !learn_pin_r) || arm_learn);

    // --------------------
    // Core next state
    // --------------------
    always_comb
    begin
        phase_nxt = phase_r;
        mode_nxt = mode_r;
        tcnt_nxt = tcnt_r;
        pd_nxt = 1'b0;
        outs_nxt = outs_r;
        hang_nxt = hang_r;
        last_in_nxt = last_in_r;
        rep_nxt = rep_r;
        bcn_nxt = bcn_r;
        rf_tx_valid_nxt = 1'b0;
        rf_tx_pkt_nxt = rf_tx_pkt_r;
        sin_nxt = sin_r;
        gap_nxt = gap_r;
        sout_nxt = sout_r;
        sidx_nxt = sidx_r;
        ser_tx_valid_nxt = ser_tx_valid_r;
        ser_tx_data_nxt = ser_tx_data_r;
        case (phase_r)
            // RULE_15 RULE_16: strap pull-down then one sample
            ST_STRAP:
            begin
                pd_nxt = 1'b1;
                tcnt_nxt = tcnt_r + 16'h0001;
                if (tcnt_r == 16'(PULLDOWN_CYCLES))
                begin
                    pd_nxt = 1'b0;
                    mode_nxt = mode_t'({mode_pin_2, mode_pin_1, mode_pin_0});
                    tcnt_nxt = 16'h0000;
                    phase_nxt = ST_WAIT;
                end
            end
            // RULE_17: ready delay
            ST_WAIT:
            begin
                if (tick)
                begin
                    tcnt_nxt = tcnt_r + 16'h0001;
                end
                if (tcnt_r == 16'(READY_MS))
                begin
                    phase_nxt = ST_RUN;
                end
            end
            ST_RUN:
            begin
            end
            default:
            begin
                phase_nxt = ST_STRAP;
            end
        endcase
        if (run && (mode_r == MODE_TX || mode_r == MODE_TX_BEACON))
        begin
            last_in_nxt = switch_in;
            if (tick)
            begin
                rep_nxt = (rep_r == 5'h00) ? 5'(REPEAT_MS - 1) : rep_r - 5'h01;
                bcn_nxt = (bcn_r == 16'h0000) ? 16'(BEACON_INTERVAL_MS - 1) : bcn_r - 16'h0001;
            end
            rf_tx_pkt_nxt.len = LEN_FULL;
            rf_tx_pkt_nxt.hdr_id = own_id_r;
            // RULE_01 RULE_03 RULE_20: state byte then id, unused bits zero
            rf_tx_pkt_nxt.data = {own_id_r[7:0], own_id_r[15:8], own_id_r[23:16],
                own_id_r[31:24], 1'b0, switch_in, 4'h0};
            if (switch_in != last_in_r || (tick && rep_r == 5'h00 && |switch_in))
            begin
                rf_tx_valid_nxt = 1'b1;
            end
            // RULE_04: beacon marking
            if (mode_r == MODE_TX_BEACON && tick && bcn_r == 16'h0000)
            begin
                rf_tx_valid_nxt = 1'b1;
                rf_tx_pkt_nxt.data[0][BIT_BEACON] = 1'b1;
                rf_tx_pkt_nxt.data[0][BIT_IN1] = 1'b1;
            end
        end
        if (run && is_ser)
        begin
            // RULE_09: gap framing of host bytes
            if (ser_rx_valid)
            begin
                gap_nxt = 5'(GAP_MS + 1);
                if (sin_r.len < LEN_FULL)
                begin
                    sin_nxt.data[sin_r.len] = ser_rx_data;
                    sin_nxt.len = sin_r.len + 3'h1;
                end
            end
            else if (tick && gap_r != 5'h00)
            begin
                gap_nxt = gap_r - 5'h01;
                if (gap_r == 5'h01)
                begin
                    rf_tx_valid_nxt = 1'b1;
                    rf_tx_pkt_nxt = sin_r;
                    rf_tx_pkt_nxt.hdr_id = own_id_r;
                    sin_nxt.len = 3'h0;
                end
            end
            if (ser_tx_valid_r && ser_tx_ready)
            begin
                sidx_nxt = sidx_r + 3'h1;
                ser_tx_data_nxt = sout_r.data[sidx_r + 3'h1];
                ser_tx_valid_nxt = (sidx_r + 3'h1) < sout_r.len;
            end
            // RULE_02 RULE_06: forward accepted packet bytes unchanged
            if (accept && !ser_tx_valid_r && rf_rx_pkt.len != 3'h0)
            begin
                sout_nxt = rf_rx_pkt;
                sidx_nxt = 3'h0;
                ser_tx_valid_nxt = 1'b1;
                ser_tx_data_nxt = rf_rx_pkt.data[0];
            end
        end
        if (run && is_rx)
        begin
            if (tick && hang_r != 10'h000)
            begin
                hang_nxt = hang_r - 10'h001;
                // RULE_19: hang expiry
                if (hang_r == 10'h001)
                begin
                    outs_nxt = 3'h0;
                end
            end
            // RULE_08 RULE_05 RULE_18: decode bits 6..4 only
            if (accept)
            begin
                outs_nxt = rf_rx_pkt.data[0][BIT_IN3:BIT_IN1];
                hang_nxt = hang_ms;
                // RULE_10: zero byte turns all off
                if (zero_pkt)
                begin
                    outs_nxt = 3'h0;
                    hang_nxt = 10'h000;
                end
            end
        end
    end

    // --------------------
    // Learn table and registers, next state
    // --------------------
    always_comb
    begin
        learning_nxt = learning_r;
        idv_nxt = idv_r;
        wptr_nxt = wptr_r;
        own_id_nxt = own_id_r;
        pkt_cnt_nxt = pkt_cnt_r + {31'h0000_0000, accept};
        // Forget first so a same-cycle store wins
        if (forget)
        begin
            idv_nxt = '0;
        end
        // RULE_14: only the header id is stored
        if (learning_r && run && rf_rx_valid && !known)
        begin
            idv_nxt[wptr_r] = 1'b1;
            wptr_nxt = wptr_r + 1'b1;
            learning_nxt = 1'b0;
        end
        if (learn_req)
        begin
            learning_nxt = 1'b1;
        end
        if (apb_done && pwrite && paddr == OFS_OWN_ID)
        begin
            own_id_nxt = pwdata;
        end
        pready_nxt = psel && penable && !pready_r;
        pslverr_nxt = 1'b0;
        prdata_nxt = 32'h0000_0000;
        if (pready_nxt)
        begin
            case (paddr)
                OFS_CTRL: prdata_nxt = 32'h0000_0000;
                OFS_STATUS: prdata_nxt = {24'h00_0000, learning_r, outs_r, run, mode_r};
                OFS_OWN_ID: prdata_nxt = own_id_r;
                OFS_PKT_CNT: prdata_nxt = pkt_cnt_r;
                default: pslverr_nxt = 1'b1;
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (learning_r && run && rf_rx_valid && !known)
        begin
            ids_r[wptr_r] <= rf_rx_pkt.hdr_id;
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            phase_r <= ST_STRAP;
            mode_r <= MODE_TX;
            tcnt_r <= 16'h0000;
            pd_r <= 1'b0;
            outs_r <= 3'h0;
            hang_r <= 10'h000;
            last_in_r <= 3'h0;
            rep_r <= 5'h00;
            bcn_r <= 16'h0000;
            rf_tx_valid_r <= 1'b0;
            rf_tx_pkt_r <= '0;
            sin_r <= '0;
            gap_r <= 5'h00;
            sout_r <= '0;
            sidx_r <= 3'h0;
            ser_tx_valid_r <= 1'b0;
            ser_tx_data_r <= 8'h00;
            learning_r <= 1'b0;
            learn_pin_r <= 1'b0;
            idv_r <= '0;
            wptr_r <= '0;
            own_id_r <= OWN_ID_RESET;
            pkt_cnt_r <= 32'h0000_0000;
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end
        else
        begin
            phase_r <= phase_nxt;
            mode_r <= mode_nxt;
            tcnt_r <= tcnt_nxt;
            pd_r <= pd_nxt;
            outs_r <= outs_nxt;
            hang_r <= hang_nxt;
            last_in_r <= last_in_nxt;
            rep_r <= rep_nxt;
            bcn_r <= bcn_nxt;
            rf_tx_valid_r <= rf_tx_valid_nxt;
            rf_tx_pkt_r <= rf_tx_pkt_nxt;
            sin_r <= sin_nxt;
            gap_r <= gap_nxt;
            sout_r <= sout_nxt;
            sidx_r <= sidx_nxt;
            ser_tx_valid_r <= ser_tx_valid_nxt;
            ser_tx_data_r <= ser_tx_data_nxt;
            learning_r <= learning_nxt;
            learn_pin_r <= learn_pin;
            idv_r <= idv_nxt;
            wptr_r <= wptr_nxt;
            own_id_r <= own_id_nxt;
            pkt_cnt_r <= pkt_cnt_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign mode_pin_0_pd_en = pd_r;
    assign learn_led = learning_r;
    assign {switch_output_3, switch_output_2, switch_output_1} = outs_r;
    assign ser_tx_valid = ser_tx_valid_r;
    assign ser_tx_data = ser_tx_data_r;
    assign rf_tx_valid = rf_tx_valid_r;
    assign rf_tx_pkt = rf_tx_pkt_r;

    // --------------------
    // Assertions
    // --------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    strap_pulldown_a: assert property (pd_r |-> phase_r == ST_STRAP) // RULE_16
        else $error("pull-down active outside strap phase");
    strap_once_a: assert property (phase_r != ST_STRAP |=> $stable(mode_r)) // RULE_15
        else $error("mode changed after strap");
    zero_clear_a: assert property (accept && is_rx && zero_pkt |=> outs_r == 3'h0) // RULE_10
        else $error("zero packet did not clear outputs");
    rx_follow_a: assert property (accept && is_rx |=> outs_r == $past(rf_rx_pkt.data[0][6:4])) // RULE_18
        else $error("outputs do not follow state bits");
    hang_load_a: assert property (accept && is_rx && !zero_pkt |=> hang_r == hang_ms) // RULE_19
        else $error("hang timer not restarted");
    net_drop_a: assert property (run && net && rf_rx_valid && !known |-> !accept) // RULE_07
        else $error("unlearned sender accepted");
    beacon_mark_a: assert property (rf_tx_valid_r && mode_r == MODE_TX_BEACON
        && rf_tx_pkt_r.data[0][0] |-> rf_tx_pkt_r.data[0][4]) // RULE_04
        else $error("beacon packet lacks bit 4");
    tx_frame_a: assert property (rf_tx_valid_r && !is_ser |-> rf_tx_pkt_r.len == LEN_FULL
        && rf_tx_pkt_r.data[1] == own_id_r[31:24] && rf_tx_pkt_r.data[0][7] == 1'b0) // RULE_01
        else $error("transmit frame malformed");
    apb_wait_a: assert property (psel && penable && !pready_r |=> pready_r) // APB register access, one wait state
        else $error("apb answer late");
    ready_time_a: assert property ($rose(run) |-> tcnt_r == 16'(READY_MS)) // RULE_17
        else $error("ready before delay");

    learn_c: cover property (learning_r ##[1:1000] !learning_r);
    fwd_c: cover property (ser_tx_valid_r && ser_tx_ready && sidx_r == 3'h4);
    hang_c: cover property (outs_r != 3'h0 ##1 outs_r == 3'h0);

endmodule : switch_state_packet_codec

//--- tb/host_serial_model.sv
/*
 * Host serial port model: takes codec bytes with random stalls, sends host bytes.
 * Assumes the codec byte handshake on mclk and a caller that steps just after an edge.
 */
`timescale 1ns/100ps
module host_serial_model (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ser_tx_valid,
    input wire logic [7:0] ser_tx_data,
    output logic ser_tx_ready,
    output logic ser_rx_valid,
    output logic [7:0] ser_rx_data,
    output logic got_v,
    output logic [7:0] got_b
);
    logic [7:0] lfsr_r;

    initial
    begin
        lfsr_r = 8'h5a;
        ser_tx_ready = 1'b0;
        ser_rx_valid = 1'b0;
        ser_rx_data = 8'h00;
        got_v = 1'b0;
        got_b = 8'h00;
    end

    // Stalling sink, one got_v per handshake
    always @(posedge mclk)
    begin
        lfsr_r <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
        ser_tx_ready <= lfsr_r[0] | lfsr_r[1];
        got_v <= rst_n & ser_tx_valid & ser_tx_ready;
        got_b <= ser_tx_data;
    end

    task send(input logic [7:0] b);
        ser_rx_valid <= 1'b1;
        ser_rx_data <= b;
        @(posedge mclk);
        ser_rx_valid <= 1'b0;
        ser_rx_data <= ~b;
    endtask : send
endmodule : host_serial_model

//--- tb/tb_switch_state_packet_codec.sv
/*
 * Self-checking bench for the switch-state packet codec in modes 6, 7, 2 and 1.
 * Assumes the host serial model and a short millisecond divider.
 */
`timescale 1ns/100ps
module tb_switch_state_packet_codec import codec_pkg::*;;
    // --------------------
    // Signals
    // --------------------
    logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, pd_en, e;
    logic learn_led, ser_tx_valid, ser_tx_ready, ser_rx_valid, rf_rx_valid, rf_tx_valid, got_v;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q, own, ha, hb;
    logic [2:0] mpins, outs, switch_in;
    logic [7:0] ser_tx_data, ser_rx_data, got_b, s;
    logic [39:0] v;
    radio_pkt_t rf_rx_pkt, rf_tx_pkt;
    logic [7:0] ser_q[$];
    radio_pkt_t rf_q[$];
    int fails, cmp_count, seed;

    switch_state_packet_codec #(.MS_DIV(20), .BEACON_INTERVAL_MS(5)) dut (
        .mclk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
        .pslverr, .mode_pin_0(mpins[0]), .mode_pin_1(mpins[1]), .mode_pin_2(mpins[2]),
        .mode_pin_0_pd_en(pd_en), .switch_in, .learn_pin(1'b0), .learn_led,
        .switch_output_1(outs[0]), .switch_output_2(outs[1]), .switch_output_3(outs[2]),
        .ser_rx_valid, .ser_rx_data, .ser_tx_valid, .ser_tx_data, .ser_tx_ready,
        .rf_rx_valid, .rf_rx_pkt, .rf_tx_valid, .rf_tx_pkt);

    host_serial_model host (.mclk, .rst_n, .ser_tx_valid, .ser_tx_data, .ser_tx_ready,
        .ser_rx_valid, .ser_rx_data, .got_v, .got_b);

    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // --------------------
    // Tasks
    // --------------------
    task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        cmp_count++;
        if (g !== x)
        begin
            fails++;
            $display("[FAIL] %s exp %h got %h", nm, x, g);
        end
    endtask : chk

    task chk_pkt(input string nm, input radio_pkt_t x, input radio_pkt_t g);
        cmp_count++;
        if (g !== x)
        begin
            fails++;
            $display("[FAIL] %s exp %h got %h", nm, x, g);
        end
    endtask : chk_pkt

    task test_done;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done

    function automatic radio_pkt_t mk(logic [2:0] n, logic [31:0] h, logic [7:0] b,
                                      logic [31:0] id);
        return {n, h, id[7:0], id[15:8], id[23:16], id[31:24], b};
    endfunction : mk

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1 && n < 40)
        begin
            @(posedge mclk);
            n++;
        end
        chk("apb_ready", 32'h1, 32'(pready));
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask : apb

    task rf(input logic [2:0] n, input logic [31:0] h, input logic [7:0] b,
            input logic [31:0] id);
        rf_rx_pkt <= mk(n, h, b, id);
        rf_rx_valid <= 1'b1;
        @(posedge mclk);
        rf_rx_valid <= 1'b0;
        rf_rx_pkt <= ~mk(n, h, b, id);
        repeat (3) @(posedge mclk);
    endtask : rf

    task boot(input logic [2:0] m);
        int n;
        n = 0;
        mpins <= m;
        rst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        chk("pulldown_on", 32'h1, 32'(pd_en));
        q = 32'h0;
        while (q[3] !== 1'b1 && n < 100)
        begin
            apb(1'b0, OFS_STATUS, 32'h0);
            n++;
        end
        chk("pulldown_off", 32'h0, 32'(pd_en));
        mpins <= ~m;
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("status_mode", {28'h0, 1'b1, m}, {28'h0, q[3:0]});
        own = $random(seed);
        apb(1'b1, OFS_OWN_ID, own);
    endtask : boot

    task drain;
        int n;
        n = 0;
        while ((ser_q.size() + rf_q.size()) != 0 && n < 2000)
        begin
            @(posedge mclk);
            n++;
        end
        chk("drained", 32'h0, 32'(ser_q.size() + rf_q.size()));
    endtask : drain

    // --------------------
    // Result watchers and watchdog
    // --------------------
    always @(posedge mclk)
    begin
        if (got_v === 1'b1 && ser_q.size() == 0)
            chk("ser_extra", 32'h0, 32'h1);
        else if (got_v === 1'b1)
            chk("ser_byte", 32'(ser_q.pop_front()), 32'(got_b));
        if (rf_tx_valid === 1'b1 && rf_q.size() != 0)
            chk_pkt("rf_pkt", rf_q.pop_front(), rf_tx_pkt);
    end

    initial
    begin
        repeat (20000) @(posedge mclk);
        chk("watchdog", 32'h0, 32'h1);
        test_done;
    end

    // --------------------
    // Sequence
    // --------------------
    initial
    begin
        seed = 97571;
        fails = 0;
        cmp_count = 0;
        {rst_n, psel, penable, pwrite, paddr, pwdata, mpins, switch_in} = '0;
        rf_rx_valid = 1'b0;
        rf_rx_pkt = '0;
        boot(3'h6);
        apb(1'b0, OFS_OWN_ID, 32'h0);
        chk("own_id", own, q);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped_err", 32'h1, 32'(e));
        chk("unmapped_rd", 32'h0, q);
        for (int k = 0; k < 8; k++)
        begin
            s = {1'b0, k[2:0], 4'h0} | (8'($random(seed)) & 8'h8e);
            rf(3'h1, $random(seed), s, 32'h0);
            chk("outputs", 32'(k), 32'(outs));
        end
        apb(1'b0, OFS_PKT_CNT, 32'h0);
        chk("pkt_cnt", 32'h8, q);
        repeat (300) @(posedge mclk);
        rf(3'h1, 32'h0, 8'h70, 32'h0);
        repeat (300) @(posedge mclk);
        chk("hang_hold", 32'h7, 32'(outs));
        repeat (200) @(posedge mclk);
        chk("hang_drop", 32'h0, 32'(outs));
        rf(3'h1, 32'h0, 8'h30, 32'h0);
        rf(3'h1, 32'h0, 8'h00, 32'h0);
        chk("zero_clear", 32'h0, 32'(outs));
        $display("test receiver_20ms done");
        boot(3'h7);
        ha = $random(seed);
        hb = ~ha;
        rf(3'h1, ha, 8'h70, 32'h0);
        chk("unlearned", 32'h0, 32'(outs));
        apb(1'b1, OFS_CTRL, 32'h1 << CTRL_LEARN);
        repeat (2) @(posedge mclk);
        chk("learn_on", 32'h1, 32'(learn_led));
        rf(3'h5, ha, 8'h00, hb);
        chk("learn_off", 32'h0, 32'(learn_led));
        rf(3'h1, hb, 8'h70, 32'h0);
        chk("data_id_unlearned", 32'h0, 32'(outs));
        rf(3'h1, ha, 8'h30, 32'h0);
        chk("learned", 32'h3, 32'(outs));
        rf(3'h5, ha, 8'h50, ~own);
        chk("wrong_own_id", 32'h3, 32'(outs));
        rf(3'h5, ha, 8'h50, own);
        chk("own_id_match", 32'h5, 32'(outs));
        $display("test network_rx done");
        boot(3'h2);
        ser_q = {8'h11, ha[31:24], ha[23:16], ha[15:8], ha[7:0]};
        rf(3'h5, ha, 8'h11, ha);
        drain;
        // host state byte keeps spare bits zero
        v = {1'b0, 3'($random(seed)), 4'h0, 32'($random(seed))};
        rf_q.push_back(mk(3'h5, own, v[39:32], v[31:0]));
        for (int i = 0; i < 5; i++)
        begin
            host.send(v[39 - 8 * i -: 8]);
            repeat (60) @(posedge mclk);
        end
        drain;
        $display("test serial done");
        boot(3'h1);
        s = {1'b0, 3'($random(seed)) | 3'h1, 4'h0};
        rf_q.push_back(mk(3'h5, own, s, own));
        switch_in <= s[6:4];
        drain;
        rf_q.push_back(mk(3'h5, own, 8'h00, own));
        switch_in <= 3'h0;
        drain;
        rf_q.push_back(mk(3'h5, own, 8'h11, own));
        drain;
        $display("test transmitter done");
        test_done;
    end
endmodule : tb_switch_state_packet_codec
